// >>> tmx_exc.sv
// Trace, monitor, breakpoint and thermal exception unit.
// Assumes completion unit obeys HOLD_CMPL and flushes on EXC.take.
`timescale 1ns/1ps
`default_nettype none
module tmx_exc
  import tmx_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire tmx_cmpl_t CMPL,
  input wire tmx_ntc_t NTC,
  input wire logic [3:0] EVENTS,
  input wire logic EXT_IRQ,
  input wire logic [1:0] THERM_CROSS,
  input wire logic SQ_EMPTY,
  output tmx_exc_t EXC,
  output logic HOLD_CMPL,
  output logic DBG_BKPT,
  output logic [31:0] MSR_WORD
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] machine_state_word;
  logic [31:0] saved_pc;
  logic [31:0] saved_st;
  logic [31:0] instr_breakpoint_addr;
  logic [31:0] instr_breakpoint_addr_eff;
  logic [31:0] sampled_instr_addr;
  logic [31:0] resume_pc;
  logic [31:0] pmc [NCNT];
  logic [31:0] mmcr [2];
  logic [31:0] thrm [2];
  logic pm_cond_q;
  tmx_state_t state;
  tmx_state_t next_state;

  // ----------------------------------------
  // Detection
  // ----------------------------------------
  logic trace_hit;
  logic bkpt_match;
  logic bkpt_take;
  logic pm_cond;
  logic pm_req;
  logic th_req;
  logic async_req;
  logic async_take;
  logic take;
  logic [31:0] cur_pc;
  logic [31:0] next_vec;
  logic [31:0] next_pc;

  assign trace_hit = CMPL.valid && !CMPL.is_isync // see RQ3
    && (machine_state_word[B_SE] || (machine_state_word[B_BE] && CMPL.is_branch)); // see RQ1
  // Compared against the copy that only moves at context sync
  assign bkpt_match = NTC.valid && instr_breakpoint_addr_eff[INSTR_BREAKPOINT_ADDR_EN] // see RQ14
    && NTC.pc[31:2] == instr_breakpoint_addr_eff[31:2]
    && instr_breakpoint_addr_eff[INSTR_BREAKPOINT_ADDR_XL] == machine_state_word[B_IR] && !EXC.take;
  assign bkpt_take = bkpt_match && !trace_hit;
  assign pm_cond = mmcr[0][PMI_EN] // see RQ6
    && |({pmc[3][31], pmc[2][31], pmc[1][31], pmc[0][31]} & mmcr[1][3:0]);
  assign pm_req = pm_cond && machine_state_word[B_EE] && !EXT_IRQ; // see RQ7
  assign th_req = machine_state_word[B_EE] && ((thrm[0][TH_FLAG] && thrm[0][TH_TIE]) // see RQ20
    || (thrm[1][TH_FLAG] && thrm[1][TH_TIE]));
  assign async_req = pm_req || th_req;
  assign async_take = state == ST_DRAIN && SQ_EMPTY // see RQ21
    && async_req && !trace_hit && !bkpt_take;
  assign take = trace_hit || bkpt_take || async_take;
  assign cur_pc = NTC.valid ? NTC.pc : resume_pc;

  // Floating-point assist has no source here, so 0x00E00 is unreachable, see RQ5
  always_comb begin
    next_vec = vec_addr(machine_state_word[B_IP], OFF_THERM); // see RQ22
    next_pc = cur_pc; // see RQ11
    if (trace_hit) begin
      next_vec = vec_addr(machine_state_word[B_IP], OFF_TRACE); // see RQ4
      next_pc = CMPL.next_pc; // see RQ2
    end else if (bkpt_take) begin
      next_vec = vec_addr(machine_state_word[B_IP], OFF_BKPT); // see RQ19
      next_pc = NTC.pc;
    end else if (pm_req) begin
      next_vec = vec_addr(machine_state_word[B_IP], OFF_PM); // see RQ23
    end
  end

  // ----------------------------------------
  // Quiesce sequence
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (async_req) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!async_req) begin
          next_state = ST_IDLE;
        end else if (CMPL.valid || !NTC.valid || trace_hit || bkpt_take) begin
          next_state = ST_DRAIN; // see RQ21
        end
      end
      ST_DRAIN: begin
        if (!async_req || async_take) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Exception outputs
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      EXC <= '0;
      HOLD_CMPL <= 1'b0;
      DBG_BKPT <= 1'b0;
    end else begin
      EXC.take <= take;
      EXC.vector <= take ? next_vec : EXC.vector;
      // Blocks the matching instruction and anything after it
      HOLD_CMPL <= take || bkpt_match || next_state == ST_DRAIN; // see RQ15
      DBG_BKPT <= bkpt_match; // see RQ16
    end
  end

  // ----------------------------------------
  // Machine state and save registers
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      machine_state_word <= MSR_RST;
    end else if (take) begin
      machine_state_word <= entry_msr(machine_state_word); // see RQ13
    end else if (WR && ADDR == A_MSR) begin
      machine_state_word <= WDATA;
    end
  end

  assign MSR_WORD = machine_state_word;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      saved_pc <= '0;
      saved_st <= '0;
    end else if (take) begin
      saved_pc <= next_pc; // see RQ11
      saved_st <= machine_state_word & KEEP_MASK; // see RQ12
    end else if (WR && ADDR == A_SPC) begin
      saved_pc <= WDATA;
    end else if (WR && ADDR == A_SST) begin
      saved_st <= WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      resume_pc <= '0;
    end else if (CMPL.valid) begin
      resume_pc <= CMPL.next_pc;
    end
  end

  // ----------------------------------------
  // Breakpoint address
  // ----------------------------------------
  // Software's copy moves at once; the compared copy only when the
  // following context sync completes, so that sync sees the old one.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      instr_breakpoint_addr <= '0;
      instr_breakpoint_addr_eff <= '0;
    end else begin
      if (WR && ADDR == A_INSTR_BREAKPOINT_ADDR) begin
        instr_breakpoint_addr <= WDATA; // see RQ17
      end
      if (CMPL.valid && CMPL.is_csync) begin
        instr_breakpoint_addr_eff <= instr_breakpoint_addr; // see RQ18
      end
    end
  end

  // ----------------------------------------
  // Performance monitor
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NCNT; i++) begin
        pmc[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (WR && ADDR == A_PMC + 8'(i * A_STEP)) begin
          pmc[i] <= WDATA;
        end else if (mmcr[0][i] && EVENTS[i]) begin
          pmc[i] <= pmc[i] + ONE; // see RQ8
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mmcr[0] <= '0;
      mmcr[1] <= '0;
    end else begin
      if (WR && ADDR == A_MMCR) begin
        mmcr[0] <= WDATA;
      end
      if (WR && ADDR == A_MMCR + A_STEP) begin
        mmcr[1] <= WDATA;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pm_cond_q <= 1'b0;
      sampled_instr_addr <= '0;
    end else begin
      pm_cond_q <= pm_cond;
      if (pm_cond && !pm_cond_q) begin
        sampled_instr_addr <= cur_pc; // see RQ10
      end else if (WR && ADDR == A_SIA) begin
        sampled_instr_addr <= WDATA;
      end
    end
  end

  // ----------------------------------------
  // Thermal thresholds
  // ----------------------------------------
  // A crossing in the cycle of a software write still sets the flag
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      thrm[0] <= '0;
      thrm[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (WR && ADDR == A_THRM + 8'(i * A_STEP)) begin
          thrm[i] <= WDATA;
        end
        if (THERM_CROSS[i]) begin
          thrm[i][TH_FLAG] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // User views are decoded for read only; writes there are dropped
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= '0;
    end else if (RD) begin
      RDATA <= '0;
      case (ADDR)
        A_MSR: RDATA <= machine_state_word;
        A_SPC: RDATA <= saved_pc;
        A_SST: RDATA <= saved_st;
        A_INSTR_BREAKPOINT_ADDR: RDATA <= instr_breakpoint_addr;
        A_SIA, A_USER_SAMPLED_VIEW: RDATA <= sampled_instr_addr; // see RQ9
        A_MMCR, A_UMMCR: RDATA <= mmcr[0];
        A_MMCR + A_STEP, A_UMMCR + A_STEP: RDATA <= mmcr[1];
        A_THRM: RDATA <= thrm[0];
        A_THRM + A_STEP: RDATA <= thrm[1];
        default: begin
          for (int i = 0; i < NCNT; i++) begin
            if (ADDR == A_PMC + 8'(i * A_STEP) || ADDR == A_UPMC + 8'(i * A_STEP)) begin
              RDATA <= pmc[i];
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_trace_take: assert property ( // see RQ1
    trace_hit |=> EXC.take && EXC.vector == vec_addr($past(machine_state_word[B_IP]), OFF_TRACE)
      && saved_pc == $past(CMPL.next_pc))
    else $error("trace not taken after completion");
  a_isync_quiet: assert property ( // see RQ3
    CMPL.valid && CMPL.is_isync |=> !(EXC.take && EXC.vector[19:0] == OFF_TRACE[19:0]))
    else $error("trace taken on instruction sync");
  a_no_fpa: assert property ( // see RQ5
    EXC.take |-> EXC.vector[19:0] != OFF_FPA[19:0])
    else $error("assist vector entered");
  a_pm_below_ext: assert property ( // see RQ7
    EXC.take && EXC.vector[19:0] == OFF_PM[19:0] |-> !$past(EXT_IRQ))
    else $error("monitor taken over external");
  a_status_save: assert property ( // see RQ12
    take |=> saved_st == ($past(machine_state_word) & KEEP_MASK))
    else $error("saved status wrong");
  a_entry_msr: assert property ( // see RQ13
    take |=> (machine_state_word & CLR_MASK) == 32'h0000_0000 && machine_state_word[B_LE] == machine_state_word[B_ILE]
      && machine_state_word[B_IP] == $past(machine_state_word[B_IP]))
    else $error("state bits not cleared");
  a_bkpt_block: assert property ( // see RQ15
    bkpt_take |=> HOLD_CMPL && DBG_BKPT && EXC.take && saved_pc == $past(NTC.pc))
    else $error("breakpoint not blocked");
  a_therm_drain: assert property ( // see RQ21
    EXC.take && EXC.vector[19:0] == OFF_THERM[19:0]
      |-> $past(SQ_EMPTY) && $past(machine_state_word[B_EE]) && $past(HOLD_CMPL))
    else $error("thermal taken before drain");
  a_sia_catch: assert property ( // see RQ10
    pm_cond && !pm_cond_q |=> sampled_instr_addr == $past(cur_pc))
    else $error("sampled address missed");
  a_count_step: assert property ( // see RQ8
    mmcr[0][0] && EVENTS[0] && !WR |=> pmc[0] == $past(pmc[0]) + ONE)
    else $error("counter did not step");

  a_bkpt_report: assert property ( // see RQ16
    bkpt_match |=> DBG_BKPT && HOLD_CMPL)
    else $error("breakpoint match not reported");
  a_bkpt_vec: assert property ( // see RQ19
    bkpt_take |=> EXC.vector == vec_addr($past(machine_state_word[B_IP]), OFF_BKPT))
    else $error("breakpoint vector wrong");
  a_trace_prio: assert property ( // see RQ2
    trace_hit && bkpt_match |=> EXC.take && EXC.vector[19:0] == OFF_TRACE[19:0])
    else $error("breakpoint taken over trace");
  a_pm_vector: assert property ( // see RQ6
    async_take && pm_req |=> EXC.take && EXC.vector == vec_addr($past(machine_state_word[B_IP]), OFF_PM))
    else $error("monitor vector wrong");
  a_therm_vec: assert property ( // see RQ22
    async_take && !pm_req |=> EXC.take && EXC.vector == vec_addr($past(machine_state_word[B_IP]), OFF_THERM))
    else $error("thermal vector wrong");
  a_hold_drain: assert property ( // see RQ21
    state == ST_DRAIN |-> HOLD_CMPL)
    else $error("completion not held while draining");
  a_vec_base: assert property ( // see RQ23
    EXC.take |-> EXC.vector[31:20] == (machine_state_word[B_IP] ? VEC_BASE_HI[31:20] : VEC_BASE_LO[31:20]))
    else $error("vector base wrong");
  a_user_ro: assert property ( // see RQ9
    WR && ADDR == A_USER_SAMPLED_VIEW && !(pm_cond && !pm_cond_q) |=> sampled_instr_addr == $past(sampled_instr_addr))
    else $error("user view was written");
  a_instr_breakpoint_addr_sync: assert property ( // see RQ18
    !(CMPL.valid && CMPL.is_csync) |=> instr_breakpoint_addr_eff == $past(instr_breakpoint_addr_eff))
    else $error("breakpoint copy moved without sync");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  c_trace: cover property (trace_hit ##1 EXC.take);
  c_bkpt: cover property (bkpt_take ##1 DBG_BKPT);
  c_pm: cover property (async_take && pm_req);
  c_therm: cover property (async_take && !pm_req);
  c_isync: cover property (CMPL.valid && CMPL.is_isync && machine_state_word[B_SE]);
endmodule
`default_nettype wire

// >>> tmx_pkg.sv
// Constants, types and helpers for the late-exception unit.
// Assumes a 32-bit core with big-endian bit numbering in the machine state.
// What this block does
// RQ1: Trace after step, or after branch in branch-trace
// RQ2: Traced instruction completes before trace is taken
// RQ3: Instruction-sync never raises a trace exception
// RQ4: Trace vectors to offset 0x00D00
// RQ5: Floating-point assist vector 0x00E00 never entered
// RQ6: Event counts trigger monitor interrupt, vector 0x00F00
// RQ7: Monitor ranks below external, above decrementer
// RQ8: Four event counters, two monitor control registers
// RQ9: User views give read-only copies of monitor state
// RQ10: Sampled address caught when monitor condition rises
// RQ11: Saved return address is next instruction address
// RQ12: Saved status keeps bits 0, 5-9, 16-31 only
// RQ13: Entry clears listed state bits, copies endian mode
// RQ14: Breakpoint on address, translation and enable match
// RQ15: Matching instruction never completes before handler
// RQ16: Every breakpoint match reported to debug port
// RQ17: Software follows breakpoint write with context sync
// RQ18: Breakpoint change takes effect after context sync
// RQ19: Breakpoint vectors to offset 0x01300
// RQ20: Thermal request needs crossing, enable and ext enable
// RQ21: Thermal waits for one completion and store drain
// RQ22: Thermal vectors to offset 0x01700
// RQ23: Base 0xFFF00000 or zero, offset added
package tmx_pkg;
  // ----------------------------------------
  // Vectors
  // ----------------------------------------
  localparam logic [31:0] VEC_BASE_HI = 32'hFFF0_0000;
  localparam logic [31:0] VEC_BASE_LO = 32'h0000_0000;
  localparam logic [31:0] OFF_TRACE = 32'h0000_0D00;
  localparam logic [31:0] OFF_FPA = 32'h0000_0E00;
  localparam logic [31:0] OFF_PM = 32'h0000_0F00;
  localparam logic [31:0] OFF_BKPT = 32'h0000_1300;
  localparam logic [31:0] OFF_THERM = 32'h0000_1700;
  // ----------------------------------------
  // Machine state bits (little-endian index)
  // ----------------------------------------
  localparam int B_EE = 15;
  localparam int B_SE = 10;
  localparam int B_BE = 9;
  localparam int B_IP = 6;
  localparam int B_IR = 5;
  localparam int B_ILE = 16;
  localparam int B_LE = 0;
  localparam logic [31:0] MSR_RST = 32'h0000_0040;
  localparam logic [31:0] KEEP_MASK = 32'h87C0_FFFF;
  localparam logic [31:0] CLR_MASK = 32'h0004_EF36;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int INSTR_BREAKPOINT_ADDR_EN = 1;
  localparam int INSTR_BREAKPOINT_ADDR_XL = 0;
  localparam int TH_FLAG = 0;
  localparam int TH_TIE = 1;
  localparam int PMI_EN = 4;
  localparam int NCNT = 4;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] A_MSR = 8'h00;
  localparam logic [7:0] A_SPC = 8'h04;
  localparam logic [7:0] A_SST = 8'h08;
  localparam logic [7:0] A_INSTR_BREAKPOINT_ADDR = 8'h0C;
  localparam logic [7:0] A_PMC = 8'h10;
  localparam logic [7:0] A_MMCR = 8'h20;
  localparam logic [7:0] A_SIA = 8'h28;
  localparam logic [7:0] A_UPMC = 8'h30;
  localparam logic [7:0] A_UMMCR = 8'h40;
  localparam logic [7:0] A_USER_SAMPLED_VIEW = 8'h48;
  localparam logic [7:0] A_THRM = 8'h50;
  localparam logic [7:0] A_STEP = 8'h04;
  localparam logic [31:0] ONE = 32'h0000_0001;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic is_branch;
    logic is_isync;
    logic is_csync;
    logic [31:0] pc;
    logic [31:0] next_pc;
  } tmx_cmpl_t;
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
  } tmx_ntc_t;
  typedef struct packed {
    logic take;
    logic [31:0] vector;
  } tmx_exc_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DRAIN = 3'b100
  } tmx_state_t;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] vec_addr(input logic ip, input logic [31:0] off);
    vec_addr = (ip ? VEC_BASE_HI : VEC_BASE_LO) + off;
  endfunction
  function automatic logic [31:0] entry_msr(input logic [31:0] m);
    logic [31:0] r;
    r = m & ~CLR_MASK;
    r[B_LE] = m[B_ILE];
    entry_msr = r;
  endfunction
endpackage

// >>> tmx_cmpl_model.sv
// Completion and fetch model facing the exception unit.
// Assumes one instruction in flight at a time, started by the bench.
`timescale 1ns/1ps
`default_nettype none
module tmx_cmpl_model
  import tmx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [31:0] pc,
  input wire logic hold,
  input wire logic take,
  output logic busy,
  output tmx_cmpl_t cmpl,
  output tmx_ntc_t ntc
);
  // -----
  // Completion
  // -----
  logic age;
  logic [2:0] k;
  logic [31:0] p;
  logic done;
  // Never in the cycle shown, never while held or flushed
  assign done = busy && age && !hold && !take;
  // Released lines show the inverse, not a stale copy
  assign cmpl = done ? {1'b1, k[0], k[1], k[2], p, p + 32'h0000_0004} :
                       {1'b0, ~k[0], ~k[1], ~k[2], ~p, ~p};
  assign ntc = busy ? {1'b1, p} : {1'b0, ~p};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      age <= 1'b0;
      k <= 3'b000;
      p <= 32'h0000_0000;
    end else if (go) begin
      busy <= 1'b1;
      age <= 1'b0;
      k <= kind;
      p <= pc;
    end else if (busy) begin
      age <= 1'b1;
      // Flush on entry: the shown instruction is dropped
      if (take || done) begin
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tmx_exc_test.sv
// Self-checking bench for the late-exception unit.
// Assumes the completion model answers on the far side.
`timescale 1ns/1ps
`default_nettype none
module tmx_exc_test
  import tmx_pkg::*;
;
  logic clk, rst_n, wr_s, rd_s, ext_irq, sq_empty, hold, dbg, go, busy;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, msr_word, ipc, m, bp, last_vec, last_np, rv;
  logic [3:0] events;
  logic [1:0] therm;
  logic [2:0] kind;
  tmx_cmpl_t cmpl;
  tmx_ntc_t ntc;
  tmx_exc_t exc;
  int n_fail, tests_run, n_take, n_done, n_dbg, t0, d0, b0, j;
  logic [31:0] tr_msr [4] = '{32'h0000_0400, 32'h0000_0400, 32'h0000_0200, 32'h0000_0200};
  logic [2:0] tr_kind [4] = '{3'b000, 3'b110, 3'b000, 3'b001};
  int tr_take [4] = '{1, 0, 0, 1};

  tmx_exc i_tmx_exc (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .CMPL(cmpl), .NTC(ntc), .EVENTS(events), .EXT_IRQ(ext_irq),
    .THERM_CROSS(therm), .SQ_EMPTY(sq_empty), .EXC(exc), .HOLD_CMPL(hold),
    .DBG_BKPT(dbg), .MSR_WORD(msr_word));
  tmx_cmpl_model i_tmx_cmpl_model (.clk(clk), .rst_n(rst_n), .go(go), .kind(kind),
    .pc(ipc), .hold(hold), .take(exc.take), .busy(busy), .cmpl(cmpl), .ntc(ntc));

  // -----
  // Tasks
  // -----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic issue(input logic [2:0] kd, input logic [31:0] a);
    int i;
    @(posedge clk);
    go <= 1'b1;
    kind <= kd;
    ipc <= a;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (i = 0; i < 20 && busy; i++) begin
      @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic mark;
    t0 = n_take;
    d0 = n_done;
    b0 = n_dbg;
  endtask
  task automatic cnt(input int et, input int ed, input int eb);
    chk(32'(n_take - t0), 32'(et));
    chk(32'(n_done - d0), 32'(ed));
    chk(32'(n_dbg - b0), 32'(eb));
  endtask
  task automatic await_take(input int n);
    int i;
    for (i = 0; i < n && n_take == t0; i++) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // -----
  // Observers
  // -----
  always @(posedge clk) begin
    if (exc.take === 1'b1) begin
      n_take++;
      last_vec = exc.vector;
      chk({31'b0, exc.vector[15:0] === 16'h0E00}, 32'h0000_0000);
    end
    if (cmpl.valid === 1'b1) begin
      n_done++;
      last_np = cmpl.next_pc;
    end
    if (dbg === 1'b1) begin
      n_dbg++;
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run is under two hundred cycles
  initial begin
    #(20 * 5000);
    n_fail++;
    complete_run;
  end

  // -----
  // Sequence
  // -----
  initial begin
    rst_n = 1'b0;
    {wr_s, rd_s, go, ext_irq} = 4'h0;
    sq_empty = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    ipc = 32'h0000_0000;
    kind = 3'b000;
    events = 4'h0;
    therm = 2'b00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(msr_word, MSR_RST);
    rdchk(A_MSR, MSR_RST);
    rdchk(8'hFC, 32'h0000_0000);
    for (j = 0; j < 4; j++) begin
      wr(A_MSR, tr_msr[j]);
      mark;
      issue(tr_kind[j], 32'h0000_0100);
      cnt(tr_take[j], 1, 0);
    end
    chk(last_vec, VEC_BASE_LO + OFF_TRACE);
    rdchk(A_SPC, 32'h0000_0104);
    bp = 32'h0000_2000;
    m = 32'h0001_8060;
    wr(A_MSR, m);
    wr(A_INSTR_BREAKPOINT_ADDR, bp | 32'h0000_0003);
    mark;
    issue(3'b100, bp);
    cnt(0, 1, 0);
    mark;
    issue(3'b000, bp);
    cnt(1, 0, 1);
    chk(last_vec, VEC_BASE_HI + OFF_BKPT);
    chk(msr_word, (m & ~CLR_MASK) | {31'b0, m[B_ILE]});
    rdchk(A_SPC, bp);
    rdchk(A_SST, m & KEEP_MASK);
    wr(A_MSR, 32'h0000_0040);
    issue(3'b100, 32'h0000_3000);
    mark;
    issue(3'b000, bp);
    cnt(0, 1, 0);
    wr(A_PMC, 32'h7FFF_FFFF);
    wr(A_PMC + 8'h04, 32'h0000_0005);
    wr(A_MMCR + 8'h04, 32'h0000_0001);
    wr(A_MMCR, 32'h0000_001F);
    ext_irq <= 1'b1;
    wr(A_MSR, 32'h0000_8040);
    mark;
    @(posedge clk);
    events <= 4'b0011;
    @(posedge clk);
    events <= 4'b0010;
    repeat (2) @(posedge clk);
    events <= 4'b0000;
    repeat (5) @(posedge clk);
    #1;
    cnt(0, 0, 0);
    rdchk(A_PMC + 8'h04, 32'h0000_0008);
    rdchk(A_PMC, 32'h8000_0000);
    wr(A_UPMC + 8'h04, 32'h0000_0000);
    rdchk(A_UPMC + 8'h04, 32'h0000_0008);
    @(posedge clk);
    ext_irq <= 1'b0;
    await_take(10);
    cnt(1, 0, 0);
    chk(last_vec, VEC_BASE_HI + OFF_PM);
    rdchk(A_SIA, bp + 32'h0000_0004);
    rdchk(A_USER_SAMPLED_VIEW, bp + 32'h0000_0004);
    rdchk(A_SPC, bp + 32'h0000_0004);
    wr(A_MMCR, 32'h0000_0000);
    sq_empty <= 1'b0;
    wr(A_THRM, 32'h0000_0002);
    wr(A_MSR, 32'h0000_0040);
    mark;
    @(posedge clk);
    therm <= 2'b01;
    @(posedge clk);
    therm <= 2'b00;
    repeat (5) @(posedge clk);
    #1;
    cnt(0, 0, 0);
    rdchk(A_THRM, 32'h0000_0003);
    wr(A_MSR, 32'h0000_8040);
    repeat (6) @(posedge clk);
    #1;
    cnt(0, 0, 0);
    chk({31'b0, hold}, 32'h0000_0001);
    @(posedge clk);
    sq_empty <= 1'b1;
    await_take(5);
    cnt(1, 0, 0);
    chk(last_vec, VEC_BASE_HI + OFF_THERM);
    rdchk(A_SPC, last_np);
    complete_run;
  end
endmodule
`default_nettype wire
